// ==== rtl/ccr_pkg.sv ====
package ccr_pkg;
    localparam logic [7:0] ILC_ADDR = 8'h06;
    localparam logic [7:0] PPC_ADDR = 8'h07;
    localparam logic [7:0] ILC_RESET = 8'hE6;
    localparam logic [7:0] PPC_RESET = 8'h4C;
    localparam int OVP_LSB = 6;
    localparam int BOOST_LSB = 4;
    localparam int VLIM_LSB = 0;
    localparam int FSD_BIT = 7;
    localparam int TSD_BIT = 6;
    localparam int BSO_BIT = 5;
    localparam int RWA_BIT = 4;
    localparam int SOD_BIT = 3;
    localparam int FSR_BIT = 2;
    localparam int TRK_LSB = 0;
    localparam logic [7:0] WDOG_MASK = 8'hC4;
    localparam int VLIM_OFFSET_MV = 3900;
    localparam int VLIM_STEP_MV = 100;
    localparam int SWITCH_DELAY_MS = 10000;
    localparam longint CLK_HZ = 100000000;
    localparam longint SWITCH_DELAY_CYC = (SWITCH_DELAY_MS * CLK_HZ) / 1000;
    localparam logic [1:0] OVP_5V85 = 2'h0;
    localparam logic [1:0] OVP_6V4 = 2'h1;
    localparam logic [1:0] OVP_11V = 2'h2;
    localparam logic [1:0] OVP_14V2 = 2'h3;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ccr_req_t;

    typedef struct packed {
        logic [1:0] input_overvoltage_sel;
        logic [1:0] boost_voltage_sel;
        logic [3:0] input_voltage_limit;
        logic force_source_detect;
        logic timer_slowdown_en;
        logic reset_with_adapter;
        logic [1:0] input_limit_tracking;
        logic battery_switch_open;
        logic system_reset_go;
        logic timer_half_speed;
        logic detect_start;
    } ccr_ctrl_t;

    typedef enum logic [3:0] {
        SW_ON = 4'h1,
        SW_WAIT = 4'h2,
        SW_OFF = 4'h4,
        SW_RESET = 4'h8
    } ccr_sw_state_t;
endpackage

// ==== rtl/ccr_regs.sv ====
`timescale 1ns/1ns
// What this block does
// - Register 06h exists, all read/write, reset value E6h.
// - 06h bits 7:6 pick overvoltage threshold 5.85/6.4/11/14.2 V, default 14.2.
// - 06h bits 3:0 set input voltage limit, 3.9 V plus 100 mV steps.
// - Register 07h exists, all read/write, reset value 4Ch.
// - Writing 1 to force-source-detect starts detection when an adapter is present.
// - Force-source-detect clears itself when detection finishes.
// - Timer-slowdown set halves safety timer during limiting, JEITA cool/warm below full charge current, thermal.
// - Battery-switch-off 1 enters ship mode after chosen delay; 0 keeps switch on.
// - Reset-with-adapter 0 waits for adapter removal; 1 resets with adapter present.
// - Switch-off delay bit 0 is immediate, 1 waits about 10 s.
// - Full-system-reset enable permits reset only while battery-switch-off is 1.
// - 07h bits 1:0 make input limit track battery plus 200/250/300 mV.
module ccr_regs #(
    parameter longint DELAY_CYCLES = ccr_pkg::SWITCH_DELAY_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire ccr_pkg::ccr_req_t req,
    input wire logic reg_reset_cmd,
    input wire logic watchdog_expired,
    input wire logic adapter_present,
    input wire logic detect_done,
    input wire logic limiting_active,
    input wire logic jeita_cool_warm,
    input wire logic charge_full_current,
    input wire logic thermal_reg_active,
    output logic [7:0] rdata,
    output logic rvalid,
    output ccr_pkg::ccr_ctrl_t ctrl
);
    import ccr_pkg::*;

    typedef struct packed {
        logic [7:0] ilc;
        logic [7:0] ppc;
        logic [7:0] rdata;
        logic rvalid;
        ccr_sw_state_t sw;
        logic [39:0] cnt;
        logic det_busy;
        ccr_ctrl_t ctrl;
    } ccr_state_t;

    ccr_state_t state_reg;
    ccr_state_t state_next;
    logic wr06;
    logic wr07;
    logic slow_cond;

    always_comb begin
        state_next = state_reg;
        wr06 = req.wr_en && req.addr == ILC_ADDR;
        wr07 = req.wr_en && req.addr == PPC_ADDR;
        state_next.rvalid = req.rd_en;
        state_next.ctrl.detect_start = 1'b0;
        if (wr06) begin
            state_next.ilc = req.wdata;
        end
        if (wr07) begin
            state_next.ppc = req.wdata;
            if (req.wdata[FSD_BIT] && !state_reg.ppc[FSD_BIT] && adapter_present) begin
                state_next.det_busy = 1'b1;
                state_next.ctrl.detect_start = 1'b1;
            end
        end
        if (state_reg.det_busy && detect_done) begin
            state_next.det_busy = 1'b0;
            state_next.ppc[FSD_BIT] = 1'b0;
        end
        if (state_next.ppc[FSD_BIT] && !state_next.det_busy && !adapter_present) begin
            state_next.ppc[FSD_BIT] = 1'b0;
        end
        if (req.rd_en) begin
            state_next.rdata = req.addr == ILC_ADDR ? state_reg.ilc :
                (req.addr == PPC_ADDR ? state_reg.ppc : 8'h00);
        end
        unique case (state_reg.sw)
            SW_ON: begin
                state_next.cnt = '0;
                if (state_reg.ppc[BSO_BIT]) begin
                    state_next.sw = state_reg.ppc[SOD_BIT] ? SW_WAIT : SW_OFF;
                end
            end
            SW_WAIT: begin
                state_next.cnt = state_reg.cnt + 40'h1;
                if (!state_reg.ppc[BSO_BIT]) begin
                    state_next.sw = SW_ON;
                end else if (state_reg.cnt >= 40'(DELAY_CYCLES - 1)) begin
                    state_next.sw = SW_OFF;
                end
            end
            SW_OFF: begin
                if (!state_reg.ppc[BSO_BIT]) begin
                    state_next.sw = SW_ON;
                end else if (state_reg.ppc[FSR_BIT] &&
                    (state_reg.ppc[RWA_BIT] || !adapter_present)) begin
                    state_next.sw = SW_RESET;
                end
            end
            SW_RESET: begin
                if (!state_reg.ppc[BSO_BIT] || !state_reg.ppc[FSR_BIT]) begin
                    state_next.sw = SW_ON;
                end
            end
        endcase
        if (watchdog_expired) begin
            state_next.ppc = (state_next.ppc & ~WDOG_MASK) | (PPC_RESET & WDOG_MASK);
            state_next.det_busy = 1'b0;
        end
        if (reg_reset_cmd) begin
            state_next.ilc = ILC_RESET;
            state_next.ppc = PPC_RESET;
            state_next.det_busy = 1'b0;
        end
        slow_cond = limiting_active || (jeita_cool_warm && !charge_full_current) ||
            thermal_reg_active;
        state_next.ctrl.input_overvoltage_sel = state_next.ilc[OVP_LSB+:2];
        state_next.ctrl.boost_voltage_sel = state_next.ilc[BOOST_LSB+:2];
        state_next.ctrl.input_voltage_limit = state_next.ilc[VLIM_LSB+:4];
        state_next.ctrl.force_source_detect = state_next.ppc[FSD_BIT];
        state_next.ctrl.timer_slowdown_en = state_next.ppc[TSD_BIT];
        state_next.ctrl.reset_with_adapter = state_next.ppc[RWA_BIT];
        state_next.ctrl.input_limit_tracking = state_next.ppc[TRK_LSB+:2];
        state_next.ctrl.timer_half_speed = state_next.ppc[TSD_BIT] && slow_cond;
        state_next.ctrl.battery_switch_open = state_next.sw != SW_ON &&
            state_next.sw != SW_WAIT;
        state_next.ctrl.system_reset_go = state_next.sw == SW_RESET;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= '0;
            state_reg.ilc <= ILC_RESET;
            state_reg.ppc <= PPC_RESET;
            state_reg.sw <= SW_ON;
            state_reg.ctrl.input_overvoltage_sel <= ILC_RESET[OVP_LSB+:2];
            state_reg.ctrl.boost_voltage_sel <= ILC_RESET[BOOST_LSB+:2];
            state_reg.ctrl.input_voltage_limit <= ILC_RESET[VLIM_LSB+:4];
            state_reg.ctrl.timer_slowdown_en <= PPC_RESET[TSD_BIT];
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata = state_reg.rdata;
    assign rvalid = state_reg.rvalid;
    assign ctrl = state_reg.ctrl;

    a_read_ilc: assert property (@(posedge sys_clk) disable iff (rst)
        req.rd_en && req.addr == ILC_ADDR && !$past(wr06) |=> rdata == $past(state_reg.ilc))
        else $error("register 06h read mismatch");
    a_reset_cmd: assert property (@(posedge sys_clk) disable iff (rst)
        reg_reset_cmd |=> state_reg.ilc == ILC_RESET && state_reg.ppc == PPC_RESET)
        else $error("register reset not applied");
    a_wdog_keep: assert property (@(posedge sys_clk) disable iff (rst)
        watchdog_expired && !reg_reset_cmd && !req.wr_en |=>
        state_reg.ppc[BSO_BIT] == $past(state_reg.ppc[BSO_BIT]))
        else $error("watchdog touched switch-off bit");
    a_immediate_off: assert property (@(posedge sys_clk) disable iff (rst)
        state_reg.sw == SW_ON && state_reg.ppc[BSO_BIT] && !state_reg.ppc[SOD_BIT] |=>
        ctrl.battery_switch_open)
        else $error("immediate switch-off late");
    a_switch_on: assert property (@(posedge sys_clk) disable iff (rst)
        !state_reg.ppc[BSO_BIT] ##1 !state_reg.ppc[BSO_BIT] |-> !ctrl.battery_switch_open)
        else $error("switch open while off bit clear");
    a_reset_gate: assert property (@(posedge sys_clk) disable iff (rst)
        ctrl.system_reset_go |-> $past(state_reg.ppc[FSR_BIT]) && $past(state_reg.ppc[BSO_BIT]))
        else $error("system reset without enable");
    a_adapter_wait: assert property (@(posedge sys_clk) disable iff (rst)
        state_reg.sw == SW_OFF && adapter_present && !state_reg.ppc[RWA_BIT] |=>
        state_reg.sw != SW_RESET)
        else $error("reset began with adapter present");
    a_detect_clear: assert property (@(posedge sys_clk) disable iff (rst)
        state_reg.det_busy && detect_done && !req.wr_en |=> !state_reg.ppc[FSD_BIT])
        else $error("detect bit not cleared");
    a_half_speed: assert property (@(posedge sys_clk) disable iff (rst)
        thermal_reg_active && state_reg.ppc[TSD_BIT] && !req.wr_en && !watchdog_expired &&
        !reg_reset_cmd |=> ctrl.timer_half_speed)
        else $error("timer not slowed");

    sequence s_quick_off_write;
        wr07 && req.wdata[BSO_BIT] && !req.wdata[SOD_BIT] && !reg_reset_cmd &&
            state_reg.sw == SW_ON && !state_reg.ppc[BSO_BIT];
    endsequence

    sequence s_reset_armed(adapter_ok);
        state_reg.sw == SW_OFF && state_reg.ppc[BSO_BIT] && state_reg.ppc[FSR_BIT] && adapter_ok;
    endsequence

    a_rvalid_rise: assert property (@(posedge sys_clk) disable iff (rst)
        req.rd_en |=> rvalid)
        else $error("read answer missing");
    a_rvalid_idle: assert property (@(posedge sys_clk) disable iff (rst)
        !req.rd_en |=> !rvalid)
        else $error("read answer without request");
    a_read_ppc: assert property (@(posedge sys_clk) disable iff (rst)
        req.rd_en && req.addr == PPC_ADDR |=> rdata == $past(state_reg.ppc))
        else $error("register 07h read mismatch");
    a_read_other: assert property (@(posedge sys_clk) disable iff (rst)
        req.rd_en && req.addr != ILC_ADDR && req.addr != PPC_ADDR |=> rdata == 8'h00)
        else $error("unmapped read not zero");

    a_write_ilc: assert property (@(posedge sys_clk) disable iff (rst)
        wr06 && !reg_reset_cmd |=> state_reg.ilc == $past(req.wdata))
        else $error("register 06h write lost");
    a_write_ppc: assert property (@(posedge sys_clk) disable iff (rst)
        wr07 && !reg_reset_cmd && !watchdog_expired && !req.wdata[FSD_BIT] |=>
        state_reg.ppc == $past(req.wdata))
        else $error("register 07h write lost");

    a_ovp_field: assert property (@(posedge sys_clk) disable iff (rst)
        ctrl.input_overvoltage_sel == state_reg.ilc[OVP_LSB+:2])
        else $error("overvoltage select differs from register");
    a_boost_field: assert property (@(posedge sys_clk) disable iff (rst)
        ctrl.boost_voltage_sel == state_reg.ilc[BOOST_LSB+:2])
        else $error("boost select differs from register");
    a_vlim_field: assert property (@(posedge sys_clk) disable iff (rst)
        ctrl.input_voltage_limit == state_reg.ilc[VLIM_LSB+:4])
        else $error("voltage limit differs from register");
    a_track_field: assert property (@(posedge sys_clk) disable iff (rst)
        ctrl.input_limit_tracking == state_reg.ppc[TRK_LSB+:2])
        else $error("tracking differs from register");
    a_rwa_field: assert property (@(posedge sys_clk) disable iff (rst)
        ctrl.reset_with_adapter == state_reg.ppc[RWA_BIT])
        else $error("reset with adapter differs from register");
    a_tsd_field: assert property (@(posedge sys_clk) disable iff (rst)
        ctrl.timer_slowdown_en == state_reg.ppc[TSD_BIT])
        else $error("timer slowdown differs from register");
    a_fsd_field: assert property (@(posedge sys_clk) disable iff (rst)
        ctrl.force_source_detect == state_reg.ppc[FSD_BIT])
        else $error("source detect differs from register");

    a_detect_launch: assert property (@(posedge sys_clk) disable iff (rst)
        wr07 && req.wdata[FSD_BIT] && !state_reg.ppc[FSD_BIT] && adapter_present |=>
        ctrl.detect_start)
        else $error("detection not started");
    a_detect_no_adapter: assert property (@(posedge sys_clk) disable iff (rst)
        state_reg.ppc[FSD_BIT] && !state_reg.det_busy && !adapter_present && !req.wr_en |=>
        !state_reg.ppc[FSD_BIT])
        else $error("detect bit kept without adapter");
    a_detect_hold: assert property (@(posedge sys_clk) disable iff (rst)
        state_reg.det_busy && state_reg.ppc[FSD_BIT] && !detect_done && !req.wr_en &&
        !watchdog_expired && !reg_reset_cmd |=> state_reg.ppc[FSD_BIT])
        else $error("detect bit dropped early");

    a_half_off: assert property (@(posedge sys_clk) disable iff (rst)
        !state_reg.ppc[TSD_BIT] && !req.wr_en && !watchdog_expired && !reg_reset_cmd |=>
        !ctrl.timer_half_speed)
        else $error("timer slowed while disabled");
    a_full_current: assert property (@(posedge sys_clk) disable iff (rst)
        !limiting_active && !thermal_reg_active && charge_full_current |=>
        !ctrl.timer_half_speed)
        else $error("timer slowed at full current");

    a_wdog_restore: assert property (@(posedge sys_clk) disable iff (rst)
        watchdog_expired && !reg_reset_cmd |=>
        (state_reg.ppc & WDOG_MASK) == (PPC_RESET & WDOG_MASK))
        else $error("watchdog bits not restored");
    a_wdog_ilc: assert property (@(posedge sys_clk) disable iff (rst)
        watchdog_expired && !reg_reset_cmd && !req.wr_en |=> $stable(state_reg.ilc))
        else $error("watchdog touched register 06h");

    a_delay_start: assert property (@(posedge sys_clk) disable iff (rst)
        state_reg.sw == SW_ON && state_reg.ppc[BSO_BIT] && state_reg.ppc[SOD_BIT] |=>
        state_reg.sw == SW_WAIT)
        else $error("switch-off delay not started");
    a_delay_hold: assert property (@(posedge sys_clk) disable iff (rst)
        state_reg.sw == SW_WAIT && state_reg.ppc[BSO_BIT] &&
        state_reg.cnt < 40'(DELAY_CYCLES - 1) |=> !ctrl.battery_switch_open)
        else $error("switch opened before delay");
    a_delay_end: assert property (@(posedge sys_clk) disable iff (rst)
        state_reg.sw == SW_WAIT && state_reg.ppc[BSO_BIT] &&
        state_reg.cnt >= 40'(DELAY_CYCLES - 1) |=> ctrl.battery_switch_open)
        else $error("switch not opened after delay");
    a_write_off_path: assert property (@(posedge sys_clk) disable iff (rst)
        s_quick_off_write |=> ##1 ctrl.battery_switch_open)
        else $error("ship mode write did not open switch");
    a_state_onehot: assert property (@(posedge sys_clk) disable iff (rst)
        $onehot(state_reg.sw))
        else $error("switch state not one-hot");

    a_reset_disable: assert property (@(posedge sys_clk) disable iff (rst)
        !state_reg.ppc[FSR_BIT] |=> !ctrl.system_reset_go)
        else $error("system reset while disabled");
    a_reset_with_adapter: assert property (@(posedge sys_clk) disable iff (rst)
        s_reset_armed(state_reg.ppc[RWA_BIT]) |=> ctrl.system_reset_go)
        else $error("reset with adapter not started");
    a_reset_no_adapter: assert property (@(posedge sys_clk) disable iff (rst)
        s_reset_armed(!adapter_present) |=> ctrl.system_reset_go)
        else $error("reset after adapter removal not started");
endmodule // ccr_regs

// ==== sim/test_charger_control_regs.sv ====
`timescale 1ns/1ns
module test_charger_control_regs;
    import ccr_pkg::*;
    localparam longint DLY = 20;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    ccr_req_t req = '0;
    logic reg_reset_cmd = 1'b0;
    logic watchdog_expired = 1'b0;
    logic adapter_present = 1'b0;
    logic detect_done = 1'b0;
    logic limiting_active = 1'b0;
    logic jeita_cool_warm = 1'b0;
    logic charge_full_current = 1'b0;
    logic thermal_reg_active = 1'b0;
    logic [7:0] rdata;
    logic rvalid;
    ccr_ctrl_t ctrl;
    int fail_count = 0;
    int checked = 0;
    int starts = 0;
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (ctrl.detect_start === 1'b1) starts <= starts + 1;
    ccr_regs #(.DELAY_CYCLES(DLY)) dut (.sys_clk(sys_clk), .rst(rst), .req(req),
        .reg_reset_cmd(reg_reset_cmd), .watchdog_expired(watchdog_expired),
        .adapter_present(adapter_present), .detect_done(detect_done),
        .limiting_active(limiting_active), .jeita_cool_warm(jeita_cool_warm),
        .charge_full_current(charge_full_current), .thermal_reg_active(thermal_reg_active),
        .rdata(rdata), .rvalid(rvalid), .ctrl(ctrl));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req.wr_en = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge sys_clk);
        req.wr_en = 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        int n;
        n = 0;
        req.rd_en = 1'b1;
        req.addr = a;
        @(negedge sys_clk);
        req.rd_en = 1'b0;
        while (rvalid !== 1'b1 && n < 4) begin
            @(negedge sys_clk);
            n++;
        end
        chk("rvalid", rvalid, 8'h01);
        chk(nm, rdata, exp);
        @(negedge sys_clk);
    endtask
    task automatic t_reset();
        rd(ILC_ADDR, 8'hE6, "input_limits_control reset");
        rd(PPC_ADDR, 8'h4C, "power_path_control reset");
        chk("ovp", ctrl.input_overvoltage_sel, 8'h03);
        chk("boost", ctrl.boost_voltage_sel, 8'h02);
        chk("vlim", ctrl.input_voltage_limit, 8'h06);
        chk("track", ctrl.input_limit_tracking, 8'h00);
        chk("slowdown", ctrl.timer_slowdown_en, 8'h01);
        $display("Test reset values done.");
    endtask
    task automatic t_rw();
        wr(ILC_ADDR, 8'h1B);
        wr(8'h08, 8'h55);
        rd(ILC_ADDR, 8'h1B, "input_limits_control rw");
        rd(8'h08, 8'h00, "unmapped");
        chk("ovp", ctrl.input_overvoltage_sel, 8'h00);
        chk("boost", ctrl.boost_voltage_sel, 8'h01);
        chk("vlim", ctrl.input_voltage_limit, 8'h0B);
        wr(PPC_ADDR, 8'h43);
        rd(PPC_ADDR, 8'h43, "power_path_control rw");
        chk("track", ctrl.input_limit_tracking, 8'h03);
        $display("Test read write done.");
    endtask
    task automatic t_detect();
        adapter_present = 1'b1;
        wr(PPC_ADDR, 8'hCC);
        cyc(3);
        chk("starts", 8'(starts), 8'h01);
        rd(PPC_ADDR, 8'hCC, "detect busy");
        chk("fsd", ctrl.force_source_detect, 8'h01);
        detect_done = 1'b1;
        cyc(1);
        detect_done = 1'b0;
        cyc(2);
        rd(PPC_ADDR, 8'h4C, "detect done");
        adapter_present = 1'b0;
        wr(PPC_ADDR, 8'hCC);
        cyc(3);
        rd(PPC_ADDR, 8'h4C, "no adapter");
        chk("starts", 8'(starts), 8'h01);
        $display("Test source detect done.");
    endtask
    task automatic t_timer();
        limiting_active = 1'b1;
        cyc(2);
        chk("half on", ctrl.timer_half_speed, 8'h01);
        wr(PPC_ADDR, 8'h0C);
        cyc(2);
        chk("half off", ctrl.timer_half_speed, 8'h00);
        limiting_active = 1'b0;
        jeita_cool_warm = 1'b1;
        charge_full_current = 1'b1;
        wr(PPC_ADDR, 8'h4C);
        cyc(2);
        chk("full cur", ctrl.timer_half_speed, 8'h00);
        charge_full_current = 1'b0;
        cyc(2);
        chk("jeita", ctrl.timer_half_speed, 8'h01);
        jeita_cool_warm = 1'b0;
        $display("Test timer slowdown done.");
    endtask
    task automatic t_switch();
        wr(PPC_ADDR, 8'h20);
        cyc(2);
        chk("off now", ctrl.battery_switch_open, 8'h01);
        wr(PPC_ADDR, 8'h00);
        cyc(2);
        chk("on", ctrl.battery_switch_open, 8'h00);
        wr(PPC_ADDR, 8'h28);
        cyc(int'(DLY) - 1);
        chk("delaying", ctrl.battery_switch_open, 8'h00);
        cyc(4);
        chk("off late", ctrl.battery_switch_open, 8'h01);
        $display("Test ship mode done.");
    endtask
    task automatic t_sysreset();
        adapter_present = 1'b1;
        wr(PPC_ADDR, 8'h64);
        cyc(3);
        chk("wait adapter", ctrl.system_reset_go, 8'h00);
        adapter_present = 1'b0;
        cyc(3);
        chk("removed", ctrl.system_reset_go, 8'h01);
        wr(PPC_ADDR, 8'h40);
        adapter_present = 1'b1;
        wr(PPC_ADDR, 8'h54);
        chk("rwa", ctrl.reset_with_adapter, 8'h01);
        wr(PPC_ADDR, 8'h74);
        cyc(3);
        chk("with adapter", ctrl.system_reset_go, 8'h01);
        wr(PPC_ADDR, 8'h70);
        cyc(3);
        chk("disabled", ctrl.system_reset_go, 8'h00);
        adapter_present = 1'b0;
        $display("Test system reset done.");
    endtask
    task automatic t_wdog();
        wr(PPC_ADDR, 8'h1B);
        watchdog_expired = 1'b1;
        cyc(1);
        watchdog_expired = 1'b0;
        cyc(1);
        rd(PPC_ADDR, 8'h5F, "watchdog 07");
        rd(ILC_ADDR, 8'h1B, "watchdog 06");
        reg_reset_cmd = 1'b1;
        cyc(1);
        reg_reset_cmd = 1'b0;
        cyc(1);
        rd(ILC_ADDR, 8'hE6, "regrst 06");
        rd(PPC_ADDR, 8'h4C, "regrst 07");
        $display("Test watchdog and reset done.");
    endtask
    task automatic summarize();
        $display("Checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        fail_count++;
        summarize();
    end
    initial begin
        cyc(6);
        rst = 1'b0;
        t_reset();
        t_rw();
        t_detect();
        t_timer();
        t_switch();
        t_sysreset();
        t_wdog();
        summarize();
    end
endmodule // test_charger_control_regs
